// ===== lisi_consts.svh
// offsets, field positions, reset values and timing counts for lisi
`ifndef LISI_CONSTS_SVH
`define LISI_CONSTS_SVH
`define LISI_IDX_INFO 8'h11
`define LISI_IDX_STATUS 8'h16
`define LISI_IDX_MASK 8'h17
`define LISI_IDX_CTRL4 8'h7B
`define LISI_IDX_LIC2 8'h79
`define LISI_IDX_TIMERCFG 8'h44
`define LISI_RST_BYTE 8'h00
`define LISI_B_CODED_MARK_ENABLE 7
`define LISI_B_CODED_MARK_INVERT 6
`define LISI_B_PRESCALE_SEL_HI 5
`define LISI_B_PRESCALE_SEL_LO 4
`define LISI_B_ETS 7
`define LISI_B_JITTER_CLK_SRC_SEL 3
`define LISI_B_INPUT_LEVEL_LOW 7
`define LISI_B_TIMER 6
`define LISI_B_SIGNALING_CHANGE_EVENT 5
`define LISI_B_JITTER_FIFO_LIMIT_TRIP 4
`define LISI_DBL_MASK 8'h8F
`define LISI_CLK_MHZ 40
`define LISI_INPUT_LEVEL_LOW_MS 50
`define LISI_INPUT_LEVEL_LOW_CYC (`LISI_INPUT_LEVEL_LOW_MS * 1000 * `LISI_CLK_MHZ)
`define LISI_CHAN_NS 5180
`define LISI_CHAN_CYC ((`LISI_CHAN_NS * `LISI_CLK_MHZ) / 1000)
`define LISI_SYNC_MATCH 32
`define LISI_SYNC_WIN 64
`define LISI_SYNC_ERR 6
`define LISI_T1_SHORT_US 42000
`define LISI_E1_SHORT_US 62500
`define LISI_LONG_US 1000000
`define LISI_RATE_T1 0
`define LISI_RATE_E1 1
`endif

// ===== lisi_pkg.sv
// types for the line interface status block
package lisi_pkg;
  typedef enum logic [2:0] {
    LISI_R1544 = 3'b000,
    LISI_R3088 = 3'b001,
    LISI_R6176 = 3'b010,
    LISI_R12352 = 3'b011,
    LISI_R2048 = 3'b100,
    LISI_R4096 = 3'b101,
    LISI_R8192 = 3'b110,
    LISI_R16384 = 3'b111
  } lisi_mclk_t;
  typedef struct packed {
    logic bert_in_sync;
    logic bit_code_detected;
    logic tx_current_limit_hit;
    logic tx_open_circuit;
    logic [3:0] rx_level;
  } lisi_info_t;
  typedef enum logic [1:0] {
    LISI_BS_HUNT = 2'b00,
    LISI_BS_SYNC = 2'b01
  } lisi_bert_in_sync_t;
endpackage : lisi_pkg

// ===== lisi_bert_sync.sv
// bert synchroniser: 32 matches to sync, 6 of 64 errors to lose it
`timescale 1ns/1ps
`include "lisi_consts.svh"
module lisi_bert_sync (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic ce,
  input wire logic bit_valid,
  input wire logic bit_error,
  output logic in_sync
);
  lisi_pkg::lisi_bert_in_sync_t state;
  logic [5:0] run;
  logic [5:0] win;
  logic [2:0] errs;
  wire step = ce && bit_valid;
  wire win_end = (win == 6'(`LISI_SYNC_WIN - 1));
  wire lose = bit_error && (errs == 3'(`LISI_SYNC_ERR - 1));
  assign in_sync = (state == lisi_pkg::LISI_BS_SYNC);
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state <= lisi_pkg::LISI_BS_HUNT;
      run <= 6'h00;
      win <= 6'h00;
      errs <= 3'h0;
    end else if (step) begin
      case (state)
        lisi_pkg::LISI_BS_HUNT: begin
          run <= bit_error ? 6'h00 : run + 6'h01;
          win <= 6'h00;
          errs <= 3'h0;
          // RQ9 sync on 32 matches
          if (!bit_error && run == 6'(`LISI_SYNC_MATCH - 1)) begin
            state <= lisi_pkg::LISI_BS_SYNC;
          end
        end
        lisi_pkg::LISI_BS_SYNC: begin
          run <= 6'h00;
          win <= win_end ? 6'h00 : win + 6'h01;
          // RQ9 lose on six errors
          if (lose) begin
            state <= lisi_pkg::LISI_BS_HUNT;
            errs <= 3'h0;
          end else if (win_end) begin
            errs <= 3'h0;
          end else begin
            errs <= errs + {2'b00, bit_error};
          end
        end
        default: state <= lisi_pkg::LISI_BS_HUNT;
      endcase
    end
  end
endmodule : lisi_bert_sync

// ===== lisi_top.sv
// line interface control, status and interrupt mask register bank
//
// Behaviour
// RQ1 - T1 prescaler decodes rate from mux bit and two select bits
// RQ2 - E1 prescaler codes mean 2.048 to 16.384 MHz master clock
// RQ3 - coded-mark invert bit inverts coded signal on tx and rx
// RQ4 - coded-mark line coding used only while enable bit set
// RQ5 - four-bit receive level code reported live in 2.5 dB bands
// RQ6 - live bit high while transmit outputs are open-circuited
// RQ7 - live bit high whenever current limiter activates
// RQ8 - live bit high while bit-oriented code detector sees valid code
// RQ9 - unlatched bert sync: 32 matches set, six of 64 errors clear
// RQ10 - tx clock lost flag after no transition for a channel time
// RQ11 - carrier lost flag set when incoming carrier lost
// RQ12 - condition flags latch both onset and end of condition
// RQ13 - jitter fifo limit flag set near limit, cleared on read
// RQ14 - signaling change flag set on enabled channel change
// RQ15 - timer flag at update interval from receive clock
// RQ16 - level-low flag only after 50 ms below threshold
// RQ17 - each flag has same-position mask bit, one enables
// RQ18 - condition flags interrupt on both edges when enabled
// RQ19 - mux bit selects jitter clock: master clock or pll
// RQ20 - interrupt output high while any enabled flag is set
//
// Our own choice: the AXI4-Lite slave port.
`timescale 1ns/1ps
`include "lisi_consts.svh"
module lisi_top #(
  parameter int INPUT_LEVEL_LOW_CYC = `LISI_INPUT_LEVEL_LOW_CYC,
  parameter int RCLK_LONG = 2048000,
  parameter int RCLK_T1_SHORT = 65024,
  parameter int RCLK_E1_SHORT = 128000
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic ce,
  input wire logic [31:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [31:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [3:0] rx_level_in,
  input wire logic tx_open_circuit,
  input wire logic tx_current_limit_hit,
  input wire logic bit_code_detected,
  input wire logic bert_bit_valid,
  input wire logic bert_bit_error,
  input wire logic li_tx_clock_in,
  input wire logic rx_carrier_lost,
  input wire logic jitter_fifo_near_limit,
  input wire logic [31:0] signaling_change,
  input wire logic rx_clock_tick,
  input wire logic [3:0] level_threshold,
  output logic coded_mark_enable,
  output logic coded_mark_invert,
  output logic jitter_clk_src_sel,
  output lisi_pkg::lisi_mclk_t mclk_rate,
  output logic irq
);
  ////////////////////////////////////////////////////////////////////////
  // register state
  logic [7:0] ctrl4;
  logic [7:0] ctrl2;
  logic [7:0] status;
  logic [7:0] mask;
  logic [7:0] timer_cfg;
  logic [31:0] cos_enable;
  lisi_pkg::lisi_info_t info;
  logic bert_sync;

  function automatic logic [7:0] lisi_index(input logic [31:0] addr);
    lisi_index = addr[9:2];
  endfunction : lisi_index

  function automatic logic lisi_is_cos(input logic [7:0] idx);
    lisi_is_cos = (idx[7:2] == 6'h10);
  endfunction : lisi_is_cos

  ////////////////////////////////////////////////////////////////////////
  // axi4-lite slave: one write and one read in flight
  logic aw_held;
  logic w_held;
  logic [7:0] aw_idx;
  logic [31:0] w_data;
  logic [3:0] w_strb;
  // ready only while ce is high, so no handshake is lost in a freeze
  assign s_axi_awready = ce && !aw_held && !s_axi_bvalid;
  assign s_axi_wready = ce && !w_held && !s_axi_bvalid;
  wire aw_fire = s_axi_awvalid && s_axi_awready;
  wire w_fire = s_axi_wvalid && s_axi_wready;
  wire aw_now = aw_held || aw_fire;
  wire w_now = w_held || w_fire;
  wire [7:0] wr_idx = aw_held ? aw_idx : lisi_index(s_axi_awaddr);
  wire [31:0] wr_dat = w_held ? w_data : s_axi_wdata;
  wire [3:0] wr_stb = w_held ? w_strb : s_axi_wstrb;
  wire wr_go = ce && aw_now && w_now && !s_axi_bvalid;
  wire wr_lane0 = wr_go && wr_stb[0];
  // write selects shared by the response code and the register updates
  wire wsel_ctrl4 = (wr_idx == `LISI_IDX_CTRL4);
  wire wsel_ctrl2 = (wr_idx == `LISI_IDX_LIC2);
  wire wsel_mask = (wr_idx == `LISI_IDX_MASK);
  wire wsel_timer = (wr_idx == `LISI_IDX_TIMERCFG);
  wire wsel_cos = lisi_is_cos(wr_idx);
  wire wr_ok = wsel_ctrl4 || wsel_ctrl2 || wsel_mask || wsel_timer ||
               wsel_cos || (wr_idx == `LISI_IDX_STATUS) ||
               (wr_idx == `LISI_IDX_INFO);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held <= 1'b0;
      w_held <= 1'b0;
      aw_idx <= 8'h00;
      w_data <= 32'h00000000;
      w_strb <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= 2'b00;
    end else if (ce) begin
      if (aw_fire) begin
        aw_held <= 1'b1;
        aw_idx <= lisi_index(s_axi_awaddr);
      end
      if (w_fire) begin
        w_held <= 1'b1;
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
      end
      if (wr_go) begin
        aw_held <= 1'b0;
        w_held <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wr_ok ? 2'b00 : 2'b10;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  assign s_axi_arready = ce && !s_axi_rvalid;
  wire ar_fire = ce && s_axi_arvalid && s_axi_arready;
  wire [7:0] rd_idx = lisi_index(s_axi_araddr);
  wire rd_status = ar_fire && (rd_idx == `LISI_IDX_STATUS);
  logic [31:0] rd_mux;
  logic rd_ok;
  always_comb begin
    rd_mux = 32'h00000000;
    rd_ok = 1'b1;
    case (rd_idx)
      `LISI_IDX_INFO: rd_mux = {24'h000000, info};
      `LISI_IDX_STATUS: rd_mux = {24'h000000, status};
      `LISI_IDX_MASK: rd_mux = {24'h000000, mask};
      `LISI_IDX_CTRL4: rd_mux = {24'h000000, ctrl4};
      `LISI_IDX_LIC2: rd_mux = {24'h000000, ctrl2};
      `LISI_IDX_TIMERCFG: rd_mux = {24'h000000, timer_cfg};
      8'h40, 8'h41, 8'h42, 8'h43: rd_mux = {24'h000000, 8'h00};
      default: rd_ok = 1'b0;
    endcase
    if (lisi_is_cos(rd_idx)) begin
      rd_mux = {24'h000000, cos_enable[8*(rd_idx[1:0]) +: 8]};
    end
  end
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= 2'b00;
    end else if (ce) begin
      if (ar_fire) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= rd_mux;
        s_axi_rresp <= rd_ok ? 2'b00 : 2'b10;
      end else if (s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // control registers
  // one write enable per enable byte of eight channels
  wire [3:0] cos_we;
  for (genvar g = 0; g < 4; g++) begin : g_cos_we
    assign cos_we[g] = wsel_cos && (wr_idx[1:0] == 2'(g));
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl4 <= `LISI_RST_BYTE;
      ctrl2 <= `LISI_RST_BYTE;
      mask <= `LISI_RST_BYTE;
      timer_cfg <= `LISI_RST_BYTE;
      cos_enable <= 32'h00000000;
    end else if (wr_lane0) begin
      if (wsel_ctrl4) begin
        ctrl4 <= wr_dat[7:0];
      end
      if (wsel_ctrl2) begin
        ctrl2 <= wr_dat[7:0];
      end
      // RQ17 mask per flag
      if (wsel_mask) begin
        mask <= wr_dat[7:0];
      end
      if (wsel_timer) begin
        timer_cfg <= wr_dat[7:0];
      end
      // RQ14 per-channel change enables
      for (int g = 0; g < 4; g++) begin
        if (cos_we[g]) begin
          cos_enable[8*g +: 8] <= wr_dat[7:0];
        end
      end
    end
  end

  wire e1_mode = ctrl2[`LISI_B_ETS];
  // RQ3 invert control
  assign coded_mark_invert = ctrl4[`LISI_B_CODED_MARK_INVERT];
  // RQ4 enable control
  assign coded_mark_enable = ctrl4[`LISI_B_CODED_MARK_ENABLE];
  // RQ19 jitter clock source
  assign jitter_clk_src_sel = ctrl2[`LISI_B_JITTER_CLK_SRC_SEL];
  // RQ1 RQ2 prescale decode; e1 always uses the 2.048 family
  assign mclk_rate = lisi_pkg::lisi_mclk_t'({jitter_clk_src_sel || e1_mode,
                       ctrl4[`LISI_B_PRESCALE_SEL_HI], ctrl4[`LISI_B_PRESCALE_SEL_LO]});

  ////////////////////////////////////////////////////////////////////////
  // real-time information
  lisi_bert_sync u_bert (
    .aclk(aclk),
    .aresetn(aresetn),
    .ce(ce),
    .bit_valid(bert_bit_valid),
    .bit_error(bert_bit_error),
    .in_sync(bert_sync)
  );
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      info <= '0;
    end else if (ce) begin
      // RQ5 RQ6 RQ7 RQ8 live bits
      info.rx_level <= rx_level_in;
      info.tx_open_circuit <= tx_open_circuit;
      info.tx_current_limit_hit <= tx_current_limit_hit;
      info.bit_code_detected <= bit_code_detected;
      // RQ9 unlatched sync
      info.bert_in_sync <= bert_sync;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // condition detectors
  logic clk_prev;
  logic [15:0] clk_idle;
  logic clk_lost;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      clk_prev <= 1'b0;
      clk_idle <= 16'h0000;
      clk_lost <= 1'b0;
    end else if (ce) begin
      clk_prev <= li_tx_clock_in;
      // RQ10 idle for a channel time
      if (clk_prev != li_tx_clock_in) begin
        clk_idle <= 16'h0000;
        clk_lost <= 1'b0;
      end else if (clk_idle == 16'(`LISI_CHAN_CYC - 1)) begin
        clk_lost <= 1'b1;
      end else begin
        clk_idle <= clk_idle + 16'h0001;
      end
    end
  end

  logic [21:0] low_cnt;
  logic level_low;
  wire below = rx_level_in > level_threshold;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      low_cnt <= 22'h000000;
      level_low <= 1'b0;
    end else if (ce) begin
      // RQ16 must stay below for the full time
      if (!below) begin
        low_cnt <= 22'h000000;
        level_low <= 1'b0;
      end else if (low_cnt == 22'(INPUT_LEVEL_LOW_CYC - 1)) begin
        level_low <= 1'b1;
      end else begin
        low_cnt <= low_cnt + 22'h000001;
      end
    end
  end

  // t1 receive clock is 1.544 of 2.048 MHz, so one second is fewer ticks
  localparam int RCLK_T1_LONG = ((RCLK_LONG / 8) * 1544) / 256;
  logic [21:0] tmr_cnt;
  wire [21:0] tmr_long = e1_mode ? 22'(RCLK_LONG) : 22'(RCLK_T1_LONG);
  wire [21:0] tmr_short = e1_mode ? 22'(RCLK_E1_SHORT) : 22'(RCLK_T1_SHORT);
  wire [21:0] tmr_len = timer_cfg[0] ? tmr_short : tmr_long;
  // RQ15 interval counted in receive clock ticks
  wire tmr_hit = rx_clock_tick && (tmr_cnt >= tmr_len - 22'h000001);
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      tmr_cnt <= 22'h000000;
    end else if (ce && rx_clock_tick) begin
      tmr_cnt <= tmr_hit ? 22'h000000 : tmr_cnt + 22'h000001;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // status latching
  logic [7:0] cond_now;
  logic [7:0] cond_prev;
  // RQ11 carrier loss condition
  assign cond_now = {level_low, 3'b000, rx_carrier_lost,
                     tx_current_limit_hit, tx_open_circuit, clk_lost};
  // RQ12 RQ18 onset and end both latch
  wire [7:0] dbl_set = (cond_now ^ cond_prev) & `LISI_DBL_MASK;
  wire [7:0] ev_set;
  // RQ13 RQ14 RQ15 event sources
  assign ev_set = {1'b0, tmr_hit, |(signaling_change & cos_enable),
                   jitter_fifo_near_limit, 4'h0};
  wire [7:0] set_bits = dbl_set | ev_set;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cond_prev <= 8'h00;
      status <= `LISI_RST_BYTE;
    end else if (ce) begin
      cond_prev <= cond_now;
      // RQ13 clear on read, set wins
      status <= (rd_status ? 8'h00 : status) | set_bits;
    end
  end

  // RQ20 masked interrupt
  assign irq = |(status & mask);
endmodule : lisi_top

// ===== lisi_monitor.sv
// concurrent checks on the line interface status block ports
`timescale 1ns/1ps
`include "lisi_consts.svh"
module lisi_top_monitor (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [31:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [31:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic s_axi_rvalid,
  input wire logic [3:0] rx_level_in,
  input wire logic tx_open_circuit,
  input wire logic tx_current_limit_hit,
  input wire logic bit_code_detected,
  input wire logic coded_mark_enable,
  input wire logic coded_mark_invert,
  input wire logic jitter_clk_src_sel,
  input wire lisi_pkg::lisi_mclk_t mclk_rate
);
  localparam logic [31:0] INFO_A = {22'h0, `LISI_IDX_INFO, 2'b00};
  localparam logic [31:0] CTL_A = {22'h0, `LISI_IDX_CTRL4, 2'b00};
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  ////////////////////////////////////////
  sequence info_rd;
    s_axi_arvalid && s_axi_arready && s_axi_araddr == INFO_A;
  endsequence
  // control outputs follow the register one edge after the write
  sequence ctl_wr;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready &&
      s_axi_awaddr == CTL_A && s_axi_wstrb[0];
  endsequence
  ////////////////////////////////////////
  level_live_a: assert property (
    info_rd |=> s_axi_rdata[3:0] == $past(rx_level_in, 2))
    else $error("receive level code not live");
  open_live_a: assert property (
    info_rd |=> s_axi_rdata[4] == $past(tx_open_circuit, 2))
    else $error("open circuit bit not live");
  limit_live_a: assert property (
    info_rd |=> s_axi_rdata[5] == $past(tx_current_limit_hit, 2))
    else $error("current limit bit not live");
  boc_live_a: assert property (
    info_rd |=> s_axi_rvalid && s_axi_rdata[6] == $past(bit_code_detected, 2))
    else $error("code detect bit not live");
  cm_enable_a: assert property (
    ctl_wr |=> coded_mark_enable == $past(s_axi_wdata[7]))
    else $error("coded mark enable not from control");
  cm_invert_a: assert property (
    ctl_wr |=> coded_mark_invert == $past(s_axi_wdata[6]))
    else $error("coded mark invert not from control");
  prescale_a: assert property (
    ctl_wr |=> mclk_rate[1:0] == $past(s_axi_wdata[5:4]))
    else $error("prescaler code not from control");
  mux_rate_a: assert property (
    jitter_clk_src_sel |-> mclk_rate[2])
    else $error("pll source without upper rate set");
endmodule : lisi_top_monitor

bind lisi_top lisi_top_monitor i_mon (
  .aclk(aclk), .aresetn(aresetn),
  .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
  .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
  .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
  .s_axi_wready(s_axi_wready), .s_axi_araddr(s_axi_araddr),
  .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
  .s_axi_rdata(s_axi_rdata), .s_axi_rvalid(s_axi_rvalid),
  .rx_level_in(rx_level_in), .tx_open_circuit(tx_open_circuit),
  .tx_current_limit_hit(tx_current_limit_hit),
  .bit_code_detected(bit_code_detected),
  .coded_mark_enable(coded_mark_enable),
  .coded_mark_invert(coded_mark_invert),
  .jitter_clk_src_sel(jitter_clk_src_sel), .mclk_rate(mclk_rate)
);

// ===== lisi_top_tb.sv
// self-checking bench for the line interface status register bank
`timescale 1ns/1ps
`include "lisi_consts.svh"
module lisi_top_tb;
  logic aclk, aresetn, ce, irq, tx_run;
  logic [31:0] s_axi_awaddr, s_axi_wdata, s_axi_araddr, s_axi_rdata;
  logic [3:0] s_axi_wstrb, rx_level_in, level_threshold;
  logic s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid;
  logic s_axi_rready, s_axi_awready, s_axi_wready, s_axi_bvalid;
  logic s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic bit_code_detected, bert_bit_valid, bert_bit_error;
  logic li_tx_clock_in, jitter_fifo_near_limit, rx_clock_tick;
  logic coded_mark_enable, coded_mark_invert, jitter_clk_src_sel;
  logic [2:0] cv;
  logic [31:0] signaling_change;
  lisi_pkg::lisi_mclk_t mclk_rate;
  wire logic tx_open_circuit = cv[0];
  wire logic tx_current_limit_hit = cv[1];
  wire logic rx_carrier_lost = cv[2];
  int err_count, n_checks, i;

  lisi_top #(.INPUT_LEVEL_LOW_CYC(20), .RCLK_LONG(40), .RCLK_T1_SHORT(8),
    .RCLK_E1_SHORT(10)) i_dut (
    .aclk(aclk), .aresetn(aresetn), .ce(ce),
    .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready), .rx_level_in(rx_level_in),
    .tx_open_circuit(tx_open_circuit),
    .tx_current_limit_hit(tx_current_limit_hit),
    .bit_code_detected(bit_code_detected),
    .bert_bit_valid(bert_bit_valid), .bert_bit_error(bert_bit_error),
    .li_tx_clock_in(li_tx_clock_in), .rx_carrier_lost(rx_carrier_lost),
    .jitter_fifo_near_limit(jitter_fifo_near_limit),
    .signaling_change(signaling_change), .rx_clock_tick(rx_clock_tick),
    .level_threshold(level_threshold),
    .coded_mark_enable(coded_mark_enable),
    .coded_mark_invert(coded_mark_invert),
    .jitter_clk_src_sel(jitter_clk_src_sel), .mclk_rate(mclk_rate),
    .irq(irq)
  );

  initial begin
    aclk = 1'b0;
    forever #12.5 aclk = ~aclk;
  end
  // transmit clock toggles unless a loss is being staged
  always @(posedge aclk) if (tx_run) li_tx_clock_in <= ~li_tx_clock_in;
  ////////////////////////////////////////
  task chk(input logic [31:0] g, input logic [31:0] e);
    n_checks++;
    if (g !== e) begin
      err_count++;
      $display("MISMATCH t=%0t value %h expected %h", $time, g, e);
    end
  endtask : chk
  task chkb(input logic g, input logic e);
    n_checks++;
    if (g !== e) begin
      err_count++;
      $display("MISMATCH t=%0t bit %b expected %b", $time, g, e);
    end
  endtask : chkb
  task cyc(input int n);
    repeat (n) @(posedge aclk);
  endtask : cyc
  // aw and w may be taken on different edges
  task wr(input logic [7:0] x, input logic [7:0] d, input logic [1:0] r);
    logic ad, wd;
    ad = 1'b0;
    wd = 1'b0;
    @(posedge aclk);
    s_axi_awaddr <= {22'h0, x, 2'b00};
    s_axi_wdata <= {24'h0, d};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    while (!(ad && wd)) begin
      @(negedge aclk);
      ad = ad | s_axi_awready;
      wd = wd | s_axi_wready;
      @(posedge aclk);
      if (ad) s_axi_awvalid <= 1'b0;
      if (wd) s_axi_wvalid <= 1'b0;
    end
    do @(negedge aclk); while (!s_axi_bvalid);
    chk({30'h0, s_axi_bresp}, {30'h0, r});
    @(posedge aclk);
    s_axi_bready <= 1'b0;
  endtask : wr
  task rd(input logic [7:0] x, input logic [7:0] d, input logic [1:0] r);
    @(posedge aclk);
    s_axi_araddr <= {22'h0, x, 2'b00};
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do @(negedge aclk); while (!s_axi_arready);
    @(posedge aclk);
    s_axi_arvalid <= 1'b0;
    do @(negedge aclk); while (!s_axi_rvalid);
    chk({30'h0, s_axi_rresp}, {30'h0, r});
    if (r == 2'b00) chk(s_axi_rdata, {24'h0, d});
    @(posedge aclk);
    s_axi_rready <= 1'b0;
  endtask : rd
  task bits(input int n, input logic e);
    repeat (n) begin
      @(posedge aclk);
      bert_bit_valid <= 1'b1;
      bert_bit_error <= e;
    end
    @(posedge aclk);
    bert_bit_valid <= 1'b0;
  endtask : bits
  task tally_and_finish;
    $display("checks %0d mismatches %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : tally_and_finish
  ////////////////////////////////////////
  initial begin
    {s_axi_awaddr, s_axi_wdata, s_axi_araddr, signaling_change} = '0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid} = '0;
    {s_axi_rready, bit_code_detected, bert_bit_valid} = '0;
    {bert_bit_error, li_tx_clock_in, jitter_fifo_near_limit} = '0;
    {rx_clock_tick, aresetn, cv, rx_level_in} = '0;
    s_axi_wstrb = 4'hF;
    level_threshold = 4'hF;
    ce = 1'b1;
    tx_run = 1'b1;
    cyc(5);
    aresetn <= 1'b1;
    rd(`LISI_IDX_INFO, 8'h00, 2'b00);
    rd(`LISI_IDX_STATUS, 8'h00, 2'b00);
    rd(`LISI_IDX_MASK, 8'h00, 2'b00);
    rd(8'h20, 8'h00, 2'b10);
    wr(`LISI_IDX_STATUS, 8'hFF, 2'b00);
    rd(`LISI_IDX_STATUS, 8'h00, 2'b00);
    for (i = 0; i < 16; i++) begin
      wr(`LISI_IDX_LIC2, {i[3], 3'h0, i[2], 3'h0}, 2'b00);
      wr(`LISI_IDX_CTRL4, {i[1:0], i[1:0], 4'h0}, 2'b00);
      rd(`LISI_IDX_CTRL4, {i[1:0], i[1:0], 4'h0}, 2'b00);
      chkb(coded_mark_enable, i[1]);
      chkb(coded_mark_invert, i[0]);
      chkb(jitter_clk_src_sel, i[2]);
      chk({29'h0, mclk_rate}, {29'h0, i[3] | i[2], i[1:0]});
      rx_level_in <= i[3:0];
      cv <= i[2:0];
      bit_code_detected <= i[3];
      cyc(3);
      rd(`LISI_IDX_INFO, {1'b0, i[3], i[1:0], i[3:0]}, 2'b00);
    end
    {cv, rx_level_in, bit_code_detected} <= '0;
    bits(31, 1'b0);
    rd(`LISI_IDX_INFO, 8'h00, 2'b00);
    bits(1, 1'b0);
    rd(`LISI_IDX_INFO, 8'h80, 2'b00);
    bits(5, 1'b1);
    rd(`LISI_IDX_INFO, 8'h80, 2'b00);
    bits(1, 1'b1);
    rd(`LISI_IDX_INFO, 8'h00, 2'b00);
    rd(`LISI_IDX_STATUS, 8'h0E, 2'b00);
    wr(`LISI_IDX_MASK, 8'h0E, 2'b00);
    rd(`LISI_IDX_MASK, 8'h0E, 2'b00);
    for (i = 0; i < 3; i++) begin
      cv <= 3'(1 << i);
      cyc(4);
      chkb(irq, 1'b1);
      rd(`LISI_IDX_STATUS, 8'(2 << i), 2'b00);
      cyc(2);
      chkb(irq, 1'b0);
      cv <= 3'h0;
      cyc(4);
      chkb(irq, 1'b1);
      rd(`LISI_IDX_STATUS, 8'(2 << i), 2'b00);
    end
    wr(`LISI_IDX_MASK, 8'h00, 2'b00);
    cv <= 3'h1;
    cyc(4);
    chkb(irq, 1'b0);
    rd(`LISI_IDX_STATUS, 8'h02, 2'b00);
    cv <= 3'h0;
    wr(`LISI_IDX_MASK, 8'h10, 2'b00);
    rd(`LISI_IDX_STATUS, 8'h02, 2'b00);
    jitter_fifo_near_limit <= 1'b1;
    cyc(1);
    jitter_fifo_near_limit <= 1'b0;
    cyc(3);
    chkb(irq, 1'b1);
    rd(`LISI_IDX_STATUS, 8'h10, 2'b00);
    rd(`LISI_IDX_STATUS, 8'h00, 2'b00);
    // an event while ce is low must be ignored
    ce <= 1'b0;
    jitter_fifo_near_limit <= 1'b1;
    cyc(1);
    jitter_fifo_near_limit <= 1'b0;
    cyc(2);
    ce <= 1'b1;
    rd(`LISI_IDX_STATUS, 8'h00, 2'b00);
    for (i = 0; i < 4; i++) wr(8'h40 + 8'(i), 8'hFF, 2'b00);
    rd(8'h40, 8'hFF, 2'b00);
    signaling_change <= 32'h0000_0001;
    cyc(1);
    signaling_change <= 32'h0;
    rd(`LISI_IDX_STATUS, 8'h20, 2'b00);
    wr(8'h41, 8'hFE, 2'b00);
    rd(8'h41, 8'hFE, 2'b00);
    signaling_change <= 32'h0000_0100;
    cyc(1);
    signaling_change <= 32'h0;
    rd(`LISI_IDX_STATUS, 8'h00, 2'b00);
    tx_run <= 1'b0;
    cyc(190);
    rd(`LISI_IDX_STATUS, 8'h00, 2'b00);
    cyc(30);
    rd(`LISI_IDX_STATUS, 8'h01, 2'b00);
    tx_run <= 1'b1;
    cyc(5);
    rd(`LISI_IDX_STATUS, 8'h01, 2'b00);
    level_threshold <= 4'h3;
    rx_level_in <= 4'h8;
    cyc(10);
    rd(`LISI_IDX_STATUS, 8'h00, 2'b00);
    cyc(12);
    rd(`LISI_IDX_STATUS, 8'h80, 2'b00);
    rx_clock_tick <= 1'b1;
    cyc(30);
    rd(`LISI_IDX_STATUS, 8'h00, 2'b00);
    cyc(12);
    rd(`LISI_IDX_STATUS, 8'h40, 2'b00);
    wr(`LISI_IDX_TIMERCFG, 8'h01, 2'b00);
    rd(`LISI_IDX_STATUS, 8'h40, 2'b00);
    cyc(4);
    rd(`LISI_IDX_STATUS, 8'h00, 2'b00);
    cyc(4);
    rd(`LISI_IDX_STATUS, 8'h40, 2'b00);
    tally_and_finish();
  end
  initial begin
    cyc(20000);
    err_count++;
    $display("MISMATCH t=%0t watchdog expired", $time);
    tally_and_finish();
  end
endmodule : lisi_top_tb
